// file: rtl/drive_supervision_monitor.v
// Stall prevention, display scaling, frequency detection and overtorque logic.
`timescale 1ns/1ps
`include "drive_supervision_consts.vh"

// Behaviour
// - Hold the accel ramp while current exceeds accel stall threshold; resume after.
// - At speed, decelerate while current exceeds run stall threshold; accelerate below.
// - Stall thresholds are percent of rated current; 100 equals rated.
// - Accel and run stall thresholds and enables are independent.
// - Display: 0 gives 0.01 Hz, 1 gives 0.01 percent, 2..39 give rpm.
// - From 40 up: fifth digit sets decimals, lower four the full-speed reading.
// - Frequency agree while output within command plus or minus width; code 02.
// - Setting agree after accel when output within accel level plus or minus width; code 03.
// - Detect one when below the phase's level during accel or decel; code 04.
// - Detect two when above the phase's level during accel or decel; code 05.
// - Overtorque when current above level continuously longer than overtorque time.
// - Any multi-function output may show overtorque detected.
// - Four overtorque modes: agree-gated or always, continue or stop.
module drive_supervision_monitor #(
  parameter OT_TICK_CYCLES = `OT_TICK_CYCLES,
  parameter NUM_OUTPUTS    = 3
) (
  input  wire                     i_clk,
  input  wire                     i_resetn,
  input  wire [15:0]              i_out_current,
  input  wire [15:0]              i_rated_current,
  input  wire [15:0]              i_out_freq,
  input  wire [15:0]              i_freq_cmd,
  input  wire [15:0]              i_max_freq,
  input  wire                     i_ramp_accel,
  input  wire                     i_ramp_decel,
  input  wire                     i_ramp_at_speed,
  input  wire                     i_accel_stall_enable,
  input  wire                     i_run_stall_enable,
  input  wire [9:0]               i_accel_stall_threshold,
  input  wire [9:0]               i_run_stall_threshold,
  input  wire [16:0]              i_display_unit_select,
  input  wire [15:0]              i_freq_detect_level_accel,
  input  wire [15:0]              i_freq_detect_level_decel,
  input  wire [15:0]              i_freq_detect_width,
  input  wire [9:0]               i_overtorque_level,
  input  wire [7:0]               i_overtorque_time,
  input  wire [1:0]               i_overtorque_mode_select,
  input  wire                     i_fault_reset,
  input  wire [4*NUM_OUTPUTS-1:0] i_output_function_select,
  output reg                      o_ramp_hold,
  output reg                      o_ramp_decel_request,
  output reg                      o_freq_agree,
  output reg                      o_set_agree,
  output reg                      o_freq_detect1,
  output reg                      o_freq_detect2,
  output reg                      o_overtorque,
  output reg                      o_stop_request,
  output reg  [15:0]              o_display_value,
  output reg  [1:0]               o_display_point,
  output reg  [NUM_OUTPUTS-1:0]   o_mfo
);

  // ========================================================================
  // Current comparisons
  // ========================================================================
  // Cross-multiplying avoids a divider: I*100 > pct*rated.
  wire [25:0] current_scaled = i_out_current * `PCT_FULL_SCALE;
  wire [25:0] accel_limit    = i_accel_stall_threshold * i_rated_current;
  wire [25:0] run_limit      = i_run_stall_threshold * i_rated_current;
  wire [25:0] ot_limit       = i_overtorque_level * i_rated_current;
  wire        accel_over     = current_scaled > accel_limit;
  wire        run_over       = current_scaled > run_limit;
  wire        ot_over        = current_scaled > ot_limit;

  // ========================================================================
  // Stall prevention
  // ========================================================================
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ramp_hold          <= 1'b0;
      o_ramp_decel_request <= 1'b0;
    end else begin
      o_ramp_hold          <= i_accel_stall_enable & i_ramp_accel & accel_over;
      o_ramp_decel_request <= i_run_stall_enable & i_ramp_at_speed & run_over;
    end
  end

  // ========================================================================
  // Frequency detection
  // ========================================================================
  wire [15:0] diff_cmd = (i_out_freq > i_freq_cmd) ? (i_out_freq - i_freq_cmd)
                                                  : (i_freq_cmd - i_out_freq);
  wire [15:0] diff_lvl = (i_out_freq > i_freq_detect_level_accel)
                         ? (i_out_freq - i_freq_detect_level_accel)
                         : (i_freq_detect_level_accel - i_out_freq);
  wire agree_now = diff_cmd <= i_freq_detect_width;
  wire set_now   = ~i_ramp_accel & (diff_lvl <= i_freq_detect_width);
  wire det1_now  = (i_ramp_accel & (i_out_freq < i_freq_detect_level_accel)) |
                   (i_ramp_decel & (i_out_freq < i_freq_detect_level_decel));
  wire det2_now  = (i_ramp_accel & (i_out_freq > i_freq_detect_level_accel)) |
                   (i_ramp_decel & (i_out_freq > i_freq_detect_level_decel));

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_freq_agree   <= 1'b0;
      o_set_agree    <= 1'b0;
      o_freq_detect1 <= 1'b0;
      o_freq_detect2 <= 1'b0;
    end else begin
      o_freq_agree   <= agree_now;
      o_set_agree    <= set_now;
      o_freq_detect1 <= det1_now;
      o_freq_detect2 <= det2_now;
    end
  end

  // ========================================================================
  // Overtorque
  // ========================================================================
  reg  [31:0] tick_cnt_reg;
  reg  [7:0]  ot_cnt_reg;
  wire        ot_enabled = i_overtorque_mode_select[`OT_MODE_ALWAYS_BIT] | agree_now;
  wire        ot_active  = ot_over & ot_enabled;
  wire        tick       = tick_cnt_reg == OT_TICK_CYCLES - 1;
  wire        ot_expired = ot_cnt_reg >= i_overtorque_time;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg   <= 32'h0000_0000;
      ot_cnt_reg     <= 8'h00;
      o_overtorque   <= 1'b0;
      o_stop_request <= 1'b0;
    end else begin
      if (!ot_active) begin
        tick_cnt_reg <= 32'h0000_0000;
        ot_cnt_reg   <= 8'h00;
      end else if (tick) begin
        tick_cnt_reg <= 32'h0000_0000;
        if (!ot_expired) begin
          ot_cnt_reg <= ot_cnt_reg + 8'h01;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
      // Longer than the time: flag on the tick after the count reaches it.
      o_overtorque <= ot_active & ot_expired & tick;
      if (ot_active & ot_expired & tick & i_overtorque_mode_select[`OT_MODE_STOP_BIT]) begin
        o_stop_request <= 1'b1;
      end else if (i_fault_reset) begin
        o_stop_request <= 1'b0;
      end
    end
  end

  // The flag above is a one-cycle pulse on each tick; hold it while the condition persists.
  reg ot_hold_reg;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ot_hold_reg <= 1'b0;
    end else if (!ot_active) begin
      ot_hold_reg <= 1'b0;
    end else if (ot_expired & tick) begin
      ot_hold_reg <= 1'b1;
    end
  end
  wire ot_indication = ot_hold_reg | o_overtorque;

  // ========================================================================
  // Multi-function outputs
  // ========================================================================
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g = g + 1) begin : mfo_gen
      wire [3:0] code = i_output_function_select[4*g +: 4];
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_mfo[g] <= 1'b0;
        end else begin
          case (code)
            `FUNC_FREQ_AGREE: o_mfo[g] <= agree_now;
            `FUNC_SET_AGREE:  o_mfo[g] <= set_now;
            `FUNC_FREQ_DET1:  o_mfo[g] <= det1_now;
            `FUNC_FREQ_DET2:  o_mfo[g] <= det2_now;
            `FUNC_OVERTORQUE: o_mfo[g] <= ot_active & (ot_hold_reg | (ot_expired & tick));
            default:          o_mfo[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ========================================================================
  // Display scaling
  // ========================================================================
  // The dividers are combinational; a multi-cycle divider would save area at
  // the price of a few cycles of display latency.
  reg  [16:0] full_scale;
  reg  [1:0]  point_next;
  reg  [15:0] value_next;
  wire [31:0] freq_x_full = i_out_freq * full_scale[13:0];
  wire [31:0] freq_x_pct  = i_out_freq * `PCT_HUNDREDTH_SCALE;
  wire [19:0] freq_x_six  = i_out_freq * `RPM_NUMERATOR;
  wire [15:0] max_safe    = (i_max_freq == 16'h0000) ? 16'h0001 : i_max_freq;
  wire [31:0] scaled_full = freq_x_full / max_safe;
  wire [31:0] scaled_pct  = freq_x_pct / max_safe;
  wire [22:0] rpm_div     = i_display_unit_select[5:0] * `RPM_DENOMINATOR;
  wire [19:0] rpm_val     = freq_x_six / ((rpm_div[19:0] == 20'h00000) ? 20'h00001 : rpm_div[19:0]);

  always @* begin
    full_scale = i_display_unit_select;
    point_next = 2'd0;
    if (i_display_unit_select >= `UNIT_POINT3_BASE) begin
      point_next = 2'd3;
      full_scale = i_display_unit_select - `UNIT_POINT3_BASE;
    end else if (i_display_unit_select >= `UNIT_POINT2_BASE) begin
      point_next = 2'd2;
      full_scale = i_display_unit_select - `UNIT_POINT2_BASE;
    end else if (i_display_unit_select >= `UNIT_POINT1_BASE) begin
      point_next = 2'd1;
      full_scale = i_display_unit_select - `UNIT_POINT1_BASE;
    end
    if (i_display_unit_select == `UNIT_HZ) begin
      value_next = i_out_freq;
      point_next = 2'd2;
    end else if (i_display_unit_select == `UNIT_PCT) begin
      value_next = scaled_pct[15:0];
      point_next = 2'd2;
    end else if (i_display_unit_select <= `UNIT_RPM_MAX) begin
      value_next = rpm_val[15:0];
      point_next = 2'd0;
    end else begin
      value_next = scaled_full[15:0];
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_display_value <= 16'h0000;
      o_display_point <= 2'd0;
    end else begin
      o_display_value <= value_next;
      o_display_point <= point_next;
    end
  end

endmodule

// file: rtl/drive_supervision_consts.vh
// Constants for the drive supervision monitor.
`ifndef DRIVE_SUPERVISION_CONSTS_VH
`define DRIVE_SUPERVISION_CONSTS_VH

// ==========================================================================
// Scaling
// ==========================================================================
`define PCT_FULL_SCALE        7'd100
`define PCT_HUNDREDTH_SCALE   14'd10000
`define RPM_NUMERATOR         4'd6
`define RPM_DENOMINATOR       4'd5
`define UNIT_HZ               17'd0
`define UNIT_PCT              17'd1
`define UNIT_RPM_MIN          17'd2
`define UNIT_RPM_MAX          17'd39
`define UNIT_POINT1_BASE      17'd10000
`define UNIT_POINT2_BASE      17'd20000
`define UNIT_POINT3_BASE      17'd30000

// ==========================================================================
// Output function codes
// ==========================================================================
`define FUNC_FREQ_AGREE       4'h2
`define FUNC_SET_AGREE        4'h3
`define FUNC_FREQ_DET1        4'h4
`define FUNC_FREQ_DET2        4'h5
`define FUNC_OVERTORQUE       4'h6

// ==========================================================================
// Overtorque mode bits
// ==========================================================================
`define OT_MODE_ALWAYS_BIT    1
`define OT_MODE_STOP_BIT      0

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS         10
`define OT_TIME_UNIT_NS       100000000
`define OT_TICK_CYCLES        (`OT_TIME_UNIT_NS / `CLK_PERIOD_NS)

`endif

// file: dv/drive_supervision_checker_asserts.sv
// Port assertions for the drive supervision monitor.
`timescale 1ns/1ps
module drive_supervision_checker #(parameter OT_TICK_CYCLES = 4, NUM_OUTPUTS = 3) (
  input wire logic        i_clk, i_resetn, i_ramp_accel, i_ramp_decel, i_ramp_at_speed,
  input wire logic        i_accel_stall_enable, i_run_stall_enable, i_fault_reset,
  input wire logic [15:0] i_out_current, i_rated_current, i_out_freq, i_freq_cmd,
  input wire logic [15:0] i_freq_detect_level_accel, i_freq_detect_level_decel,
  input wire logic [15:0] i_freq_detect_width,
  input wire logic [9:0]  i_accel_stall_threshold, i_run_stall_threshold, i_overtorque_level,
  input wire logic [4*NUM_OUTPUTS-1:0] i_output_function_select,
  input wire logic        o_ramp_hold, o_ramp_decel_request, o_freq_agree, o_set_agree,
  input wire logic        o_freq_detect1, o_freq_detect2, o_overtorque, o_stop_request,
  input wire logic [NUM_OUTPUTS-1:0] o_mfo
);
  // ====================
  // Reference conditions
  // Products are kept 32 bits wide so that large ratings cannot wrap.
  wire [31:0] cur = i_out_current * 32'h00000064;
  wire [31:0] rat = {16'h0000, i_rated_current};
  wire [16:0] f = {1'b0, i_out_freq};
  wire [16:0] la = {1'b0, i_freq_detect_level_accel};
  wire [16:0] ld = {1'b0, i_freq_detect_level_decel};
  wire [16:0] w = {1'b0, i_freq_detect_width};
  wire acc_c = i_ramp_accel && i_accel_stall_enable && cur > i_accel_stall_threshold * rat;
  wire run_c = i_ramp_at_speed && i_run_stall_enable && cur > i_run_stall_threshold * rat;
  wire ot_c = cur > i_overtorque_level * rat;
  wire agr_c = f <= i_freq_cmd + w && i_freq_cmd <= f + w;
  wire set_c = !i_ramp_accel && f <= la + w && la <= f + w;
  wire det1 = (i_ramp_accel && f < la) || (i_ramp_decel && f < ld);
  wire det2 = (i_ramp_accel && f > la) || (i_ramp_decel && f > ld);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // The first edge after reset release is not checked, since $past(i_resetn) is still low there.
  a_accel_stall_hold: assert property ($past(i_resetn) |-> o_ramp_hold == $past(acc_c))
    else $error("bad hold");
  a_run_stall_decel: assert property ($past(i_resetn) |-> o_ramp_decel_request == $past(run_c))
    else $error("bad run stall");
  a_freq_agree_win: assert property ($past(i_resetn) |-> o_freq_agree == $past(agr_c))
    else $error("bad agree");
  a_set_agree_win: assert property ($past(i_resetn) |-> o_set_agree == $past(set_c))
    else $error("bad set");
  a_detect_one_lvl: assert property ($past(i_resetn) |-> o_freq_detect1 == $past(det1))
    else $error("bad d1");
  a_detect_two_lvl: assert property ($past(i_resetn) |-> o_freq_detect2 == $past(det2))
    else $error("bad d2");
  a_mfo_agree_route: assert property ($past(i_output_function_select[3:0]) == 4'h2
    |-> o_mfo[0] == o_freq_agree) else $error("bad route");
  a_ot_needs_current: assert property (o_overtorque |-> $past(ot_c) && $past(ot_c, 2))
    else $error("bad overtorque");
  a_stop_stays_set: assert property (o_stop_request && !i_fault_reset |=> o_stop_request)
    else $error("stop lost");
  c_hold: cover property (o_ramp_hold);
  c_run: cover property (o_ramp_decel_request);
  c_stop: cover property (o_overtorque && o_stop_request);
endmodule
bind drive_supervision_monitor drive_supervision_checker #(.OT_TICK_CYCLES(OT_TICK_CYCLES),
  .NUM_OUTPUTS(NUM_OUTPUTS)) chk_inst (.*);

// file: dv/drive_ramp_model.sv
// Ramp generator model that obeys the hold and decelerate requests.
`timescale 1ns/1ps
module drive_ramp_model #(parameter logic [15:0] STEP = 16'h0032) (
  input  wire logic        i_clk, i_resetn, i_hold, i_decel_req,
  input  wire logic [15:0] i_target,
  output logic      [15:0] o_freq,
  output wire logic        o_accel, o_decel, o_at_speed
);
  // ====================
  // Ramp
  // A hold freezes the level but keeps the accelerating flag, as a real ramp would.
  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn) o_freq <= 16'h0000;
    else if (i_decel_req && o_freq >= STEP) o_freq <= o_freq - STEP;
    else if (o_freq < i_target && !i_hold) o_freq <= o_freq + STEP;
    else if (o_freq > i_target) o_freq <= o_freq - STEP;
  assign o_decel = i_decel_req || o_freq > i_target;
  assign o_accel = !o_decel && o_freq < i_target;
  assign o_at_speed = !o_decel && o_freq == i_target;
endmodule

// file: dv/drive_supervision_monitor_test.sv
// Self-checking testbench for the drive supervision monitor.
`timescale 1ns/1ps
module drive_supervision_monitor_test;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_accel_stall_enable = 1'b1, i_run_stall_enable = 1'b1;
  logic i_fault_reset = 1'b0, i_ramp_accel, i_ramp_decel, i_ramp_at_speed, mf;
  logic [15:0] i_out_current = 16'h01F4, i_rated_current = 16'h03E8, i_max_freq = 16'h1770;
  logic [15:0] i_freq_cmd = 16'h0000, tgt = 16'h0000, i_freq_detect_width = 16'h0014;
  logic [15:0] i_freq_detect_level_accel = 16'h0BB8, i_freq_detect_level_decel = 16'h07D0;
  logic [15:0] i_out_freq, o_display_value, fz;
  logic [9:0] i_accel_stall_threshold = 10'h096, i_run_stall_threshold = 10'h078;
  logic [9:0] i_overtorque_level = 10'h096;
  logic [7:0] i_overtorque_time = 8'h02;
  logic [1:0] i_overtorque_mode_select = 2'h3, o_display_point;
  logic [16:0] i_display_unit_select = 17'h00000;
  logic [11:0] i_output_function_select = 12'hF62;
  logic o_ramp_hold, o_ramp_decel_request, o_freq_agree, o_set_agree, o_freq_detect1;
  logic o_freq_detect2, o_overtorque, o_stop_request;
  logic [2:0] o_mfo;
  int n_fail = 0, cmp_count = 0, cycles = 0, at;
  // Display cases: unit select, expected value, decimal count.
  logic [16:0] du [7] = '{17'h0, 17'h1, 17'h4, 17'h6784, 17'h7F2B, 17'h2EE0, 17'h6784};
  logic [15:0] dv [7] = '{16'h1770, 16'h1388, 16'h0708, 16'h1964, 16'h09FB, 16'h04B0, 16'h0F3C};
  logic [1:0] dp [7] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
  drive_supervision_monitor #(.OT_TICK_CYCLES(4)) drive_supervision_monitor_inst (.*);
  drive_ramp_model drive_ramp_model_inst (.i_clk, .i_resetn, .i_target(tgt),
    .i_hold(o_ramp_hold), .i_decel_req(o_ramp_decel_request), .o_freq(i_out_freq),
    .o_accel(i_ramp_accel), .o_decel(i_ramp_decel), .o_at_speed(i_ramp_at_speed));
  // ====================
  // Clock, timeout and helpers
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic goto(input logic [15:0] v);
    int k;
    @(posedge i_clk);
    tgt <= v;
    i_freq_cmd <= v;
    for (k = 0; k < 400 && !(i_ramp_at_speed === 1'b1 && i_out_freq === v); k++) wait_clk(1);
    check("ramp", k < 400, 1);
    wait_clk(2);
  endtask
  // Current is high for hi cycles; at is the cycle of the first overtorque pulse.
  task automatic ot_run(input int hi, output int at, output logic mf);
    at = 99;
    mf = 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clk);
      i_out_current <= (n < hi) ? 16'h0640 : 16'h01F4;
      #1;
      if (o_overtorque === 1'b1 && at == 99) begin
        at = n;
        mf = o_mfo[1];
      end
    end
  endtask
  // ====================
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    tgt <= 16'h1770;
    i_freq_cmd <= 16'h1770;
    wait_clk(20);
    i_out_current <= 16'h0640;
    wait_clk(2);
    check("hold", o_ramp_hold, 1);
    check("detect one", o_freq_detect1, 1);
    check("detect two", o_freq_detect2, 0);
    fz = i_out_freq;
    wait_clk(4);
    check("frozen", i_out_freq, fz);
    i_out_current <= 16'h0578;
    wait_clk(2);
    check("hold at 140", o_ramp_hold, 0);
    // Drop below the run stall level so the ramp settles at speed.
    i_out_current <= 16'h01F4;
    goto(16'h1770);
    check("agree", o_freq_agree, 1);
    check("mfo", o_mfo, 3'h1);
    check("set agree", o_set_agree, 0);
    i_freq_detect_level_accel <= 16'h1770;
    i_out_current <= 16'h0514;
    wait_clk(1);
    check("run stall", o_ramp_decel_request, 1);
    wait_clk(1);
    check("slowing", i_out_freq, 16'h173E);
    check("set agree", o_set_agree, 1);
    i_run_stall_enable <= 1'b0;
    goto(16'h1770);
    check("run stall off", o_ramp_decel_request, 0);
    for (int i = 0; i < 7; i++) begin
      if (i == 5) goto(16'h0E10);
      i_display_unit_select <= du[i];
      i_max_freq <= (i == 1) ? 16'h2EE0 : 16'h1770;
      wait_clk(2);
      check("display", o_display_value, dv[i]);
      check("point", o_display_point, dp[i]);
    end
    goto(16'h1770);
    ot_run(6, at, mf);
    check("ot restart", at, 99);
    for (int m = 0; m < 4; m++) begin
      i_overtorque_mode_select <= m[1:0];
      i_fault_reset <= 1'b1;
      wait_clk(1);
      i_fault_reset <= 1'b0;
      ot_run(30, at, mf);
      check("ot time", at >= 9 && at <= 20, 1);
      check("ot mfo", mf, 1);
      check("stop", o_stop_request, m[0]);
    end
    i_overtorque_mode_select <= 2'h0;
    i_freq_cmd <= 16'h1388;
    ot_run(30, at, mf);
    check("ot gated", at, 99);
    end_sim();
  end
endmodule
